/* File: common/csrb_pkg.sv */
// constants and types shared by the configurable synchronous ram block
// assumes a single system clock; everything here is elaboration-time only
package csrb_pkg;
	// ==========================================================
	// storage geometry
	localparam int MEM_BITS = 2048;
	localparam int ADDR_W = 11;
	localparam int DATA_W = 8;
	localparam int NUM_CLK_SRC = 3;
	// ==========================================================
	// word-by-width organisations
	typedef enum logic [1:0]
	{
		ORG_256X8 = 2'b00,
		ORG_512X4 = 2'b01,
		ORG_1024X2 = 2'b10,
		ORG_2048X1 = 2'b11
	} csrb_org_t;
	// ==========================================================
	// source selects for block clocks and write request
	localparam logic [1:0] CLK_SRC_GLOBAL = 2'h0;
	localparam logic [1:0] CLK_SRC_DEDICATED = 2'h1;
	localparam logic [1:0] CLK_SRC_LOCAL = 2'h2;
	localparam logic WR_SRC_GLOBAL = 1'h0;
	localparam logic WR_SRC_LOCAL = 1'h1;
	// ==========================================================
	// reset values
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;
	localparam logic [MEM_BITS-1:0] MEM_RST = '0;
endpackage

/* File: core/csrb_ram_block.sv */
// configurable synchronous ram block: 2048 flip-flop bits, four aspect ratios, lookup mode
// assumes all inputs synchronous to clock_i; side clocks arrive as sampled levels
//
// Contract
// RQ1: block stores 2048 bits, usable as ram, rom, dual-port ram or fifo store; here reads and writes share the one address port addr_i.
// RQ2: organisation selectable as 256x8, 512x4, 1024x2 or 2048x1.
// RQ3: block makes its own write strobe from the clock; user gives a write request.
// RQ4: input side and output side each follow their own independent clock.
// RQ5: data-in, data-out and address/write-request registers each enabled or bypassed.
// RQ6: write request from global or local; side clocks from global, dedicated or local.
// RQ7: wider words come from parallel blocks sharing address, each a slice.
// RQ8: deeper memories use a block select decoded per access, same timing.
// RQ9: lookup contents loaded at configuration, then read back as a function of address.
// RQ10: address width follows depth, data width is 2048/depth, extra address bits ignored.
`timescale 1ns/1ps
module csrb_ram_block
#(
	parameter int MEM_BITS = csrb_pkg::MEM_BITS,
	parameter int ADDR_W = csrb_pkg::ADDR_W,
	parameter int DATA_W = csrb_pkg::DATA_W
)
(
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic [1:0] org_i,
	input wire logic rom_mode_i,
	input wire logic reg_din_en_i,
	input wire logic reg_dout_en_i,
	input wire logic reg_addr_en_i,
	input wire logic [csrb_pkg::NUM_CLK_SRC-1:0] in_clk_src_i,
	input wire logic [1:0] in_clk_sel_i,
	input wire logic [csrb_pkg::NUM_CLK_SRC-1:0] out_clk_src_i,
	input wire logic [1:0] out_clk_sel_i,
	input wire logic wr_req_global_i,
	input wire logic wr_req_local_i,
	input wire logic wr_src_sel_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic blk_sel_i,
	input wire logic [DATA_W-1:0] din_i,
	input wire logic cfg_load_i,
	input wire logic [ADDR_W-1:0] cfg_addr_i,
	input wire logic cfg_bit_i,
	output logic [DATA_W-1:0] dout_o,
	output logic wr_strobe_o
);
	// ==========================================================
	// helpers
	// bit index of the word's lowest bit; upper address bits dropped per depth
	function automatic logic [ADDR_W-1:0] word_base(input logic [1:0] org, input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] b;
		b = a;
		case (org)
			csrb_pkg::ORG_256X8: b = {a[7:0], 3'h0};
			csrb_pkg::ORG_512X4: b = {a[8:0], 2'h0};
			csrb_pkg::ORG_1024X2: b = {a[9:0], 1'h0};
			default: b = a;
		endcase
		return b;
	endfunction

	// live data lanes for the organisation
	function automatic logic [DATA_W-1:0] word_mask(input logic [1:0] org);
		logic [DATA_W-1:0] m;
		m = 8'hff;
		case (org)
			csrb_pkg::ORG_256X8: m = 8'hff;
			csrb_pkg::ORG_512X4: m = 8'h0f;
			csrb_pkg::ORG_1024X2: m = 8'h03;
			default: m = 8'h01;
		endcase
		return m;
	endfunction

	function automatic logic pick_clk(input logic [csrb_pkg::NUM_CLK_SRC-1:0] src, input logic [1:0] sel);
		logic c;
		c = src[0];
		case (sel)
			csrb_pkg::CLK_SRC_GLOBAL: c = src[0];
			csrb_pkg::CLK_SRC_DEDICATED: c = src[1];
			csrb_pkg::CLK_SRC_LOCAL: c = src[2];
			default: c = src[0];
		endcase
		return c;
	endfunction

	// ==========================================================
	// state
	logic in_clk_prev_r, in_clk_prev_nxt;
	logic out_clk_prev_r, out_clk_prev_nxt;
	logic [ADDR_W-1:0] addr_q_r, addr_q_nxt;
	logic we_q_r, we_q_nxt;
	logic sel_q_r, sel_q_nxt;
	logic [DATA_W-1:0] din_q_r, din_q_nxt;
	logic [DATA_W-1:0] dout_q_r, dout_q_nxt;
	logic [DATA_W-1:0] dout_r, dout_nxt;
	logic wr_strobe_r, wr_strobe_nxt;
	logic [MEM_BITS-1:0] mem_r, mem_nxt;

	logic in_clk_lvl, out_clk_lvl, in_tick, out_tick;
	logic wr_req, we_eff, sel_eff, wr_pulse;
	logic [ADDR_W-1:0] addr_eff, base_eff, idx;
	logic [DATA_W-1:0] din_eff, mask, rd_word;

	// ==========================================================
	// side clocks and request sources
	always_comb
	begin
		in_clk_lvl = pick_clk(in_clk_src_i, in_clk_sel_i); // [RQ6]
		out_clk_lvl = pick_clk(out_clk_src_i, out_clk_sel_i); // [RQ6]
		in_tick = in_clk_lvl & ~in_clk_prev_r; // [RQ4]
		out_tick = out_clk_lvl & ~out_clk_prev_r; // [RQ4]
		wr_req = (wr_src_sel_i == csrb_pkg::WR_SRC_LOCAL) ? wr_req_local_i : wr_req_global_i; // [RQ6]
		in_clk_prev_nxt = in_clk_lvl;
		out_clk_prev_nxt = out_clk_lvl;
	end

	// ==========================================================
	// optional input registers and self-timed write strobe
	always_comb
	begin
		addr_q_nxt = in_tick ? addr_i : addr_q_r; // [RQ5]
		we_q_nxt = in_tick ? wr_req : we_q_r; // [RQ5]
		sel_q_nxt = in_tick ? blk_sel_i : sel_q_r;
		din_q_nxt = in_tick ? din_i : din_q_r; // [RQ5]
		addr_eff = reg_addr_en_i ? addr_q_r : addr_i; // [RQ5]
		we_eff = reg_addr_en_i ? we_q_r : wr_req;
		sel_eff = reg_addr_en_i ? sel_q_r : blk_sel_i; // [RQ8]
		din_eff = reg_din_en_i ? din_q_r : din_i; // [RQ5]
		mask = word_mask(org_i); // [RQ2] [RQ10]
		base_eff = word_base(org_i, addr_eff); // [RQ10]
		// strobe fires once per input clock edge that carries a selected write request outside lookup mode and config load, no user pulse shaping
		wr_pulse = in_tick & we_eff & sel_eff & ~rom_mode_i & ~cfg_load_i; // [RQ3] [RQ8] [RQ9]
		wr_strobe_nxt = wr_pulse; // [RQ3]
	end

	// ==========================================================
	// storage: configuration load wins over user write
	always_comb
	begin
		mem_nxt = mem_r;
		idx = base_eff;
		if (cfg_load_i)
		begin
			mem_nxt[cfg_addr_i] = cfg_bit_i; // [RQ9]
		end
		else if (wr_pulse)
		begin
			for (int k = 0; k < DATA_W; k++)
			begin
				idx = base_eff + ADDR_W'(k);
				if (mask[k])
				begin
					mem_nxt[idx] = din_eff[k]; // [RQ1] [RQ2]
				end
			end
		end
	end

	// ==========================================================
	// read path; unselected block reads zero so slices and banks can be or-ed
	always_comb
	begin
		rd_word = csrb_pkg::DATA_RST;
		for (int k = 0; k < DATA_W; k++)
		begin
			rd_word[k] = mask[k] & sel_eff & mem_r[base_eff + ADDR_W'(k)]; // [RQ7] [RQ8] [RQ9]
		end
		dout_q_nxt = out_tick ? rd_word : dout_q_r; // [RQ4] [RQ5]
		dout_nxt = reg_dout_en_i ? dout_q_r : rd_word; // [RQ5]
	end

	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			in_clk_prev_r <= 1'h0;
			out_clk_prev_r <= 1'h0;
			addr_q_r <= csrb_pkg::ADDR_RST;
			we_q_r <= 1'h0;
			sel_q_r <= 1'h0;
			din_q_r <= csrb_pkg::DATA_RST;
			dout_q_r <= csrb_pkg::DATA_RST;
			dout_r <= csrb_pkg::DATA_RST;
			wr_strobe_r <= 1'h0;
			mem_r <= csrb_pkg::MEM_RST;
		end
		else
		begin
			in_clk_prev_r <= in_clk_prev_nxt;
			out_clk_prev_r <= out_clk_prev_nxt;
			addr_q_r <= addr_q_nxt;
			we_q_r <= we_q_nxt;
			sel_q_r <= sel_q_nxt;
			din_q_r <= din_q_nxt;
			dout_q_r <= dout_q_nxt;
			dout_r <= dout_nxt;
			wr_strobe_r <= wr_strobe_nxt;
			mem_r <= mem_nxt;
		end
	end

	assign dout_o = dout_r;
	assign wr_strobe_o = wr_strobe_r;

	// ==========================================================
	// assertions
	property p_lane_mask;
		@(posedge clock_i) disable iff (reset_i)
		(org_i == $past(org_i)) |-> ((dout_o & ~word_mask(org_i)) == 8'h00);
	endproperty
	a_lane_mask: assert property (p_lane_mask) else $error("dead lane nonzero"); // [RQ2]

	property p_strobe_from_req;
		@(posedge clock_i) disable iff (reset_i)
		(in_tick && we_eff && sel_eff && !rom_mode_i && !cfg_load_i) |=> wr_strobe_o;
	endproperty
	a_strobe_from_req: assert property (p_strobe_from_req) else $error("write strobe missing"); // [RQ3]

	property p_strobe_needs_tick;
		@(posedge clock_i) disable iff (reset_i)
		wr_strobe_o |-> ($past(in_tick) && $past(we_eff));
	endproperty
	a_strobe_needs_tick: assert property (p_strobe_needs_tick) else $error("stray write strobe"); // [RQ4]

	property p_rom_no_write;
		@(posedge clock_i) disable iff (reset_i)
		rom_mode_i |=> !wr_strobe_o;
	endproperty
	a_rom_no_write: assert property (p_rom_no_write) else $error("write in lookup mode"); // [RQ9]

	property p_cfg_load;
		@(posedge clock_i) disable iff (reset_i)
		cfg_load_i |=> (mem_r[$past(cfg_addr_i)] == $past(cfg_bit_i));
	endproperty
	a_cfg_load: assert property (p_cfg_load) else $error("config bit not stored"); // [RQ9]

	property p_write_readback;
		@(posedge clock_i) disable iff (reset_i)
		(wr_pulse && !reg_dout_en_i) ##1 ($stable(base_eff) && $stable(org_i) && sel_eff && !reg_dout_en_i
			&& !wr_pulse && !cfg_load_i) |=> (dout_o == ($past(din_eff, 2) & word_mask(org_i)));
	endproperty
	a_write_readback: assert property (p_write_readback) else $error("read after write wrong"); // [RQ1]

	property p_dout_reg_hold;
		@(posedge clock_i) disable iff (reset_i)
		(reg_dout_en_i && !out_tick) ##1 reg_dout_en_i |=> $stable(dout_o);
	endproperty
	a_dout_reg_hold: assert property (p_dout_reg_hold) else $error("registered output moved"); // [RQ5]

	property p_unselected_zero;
		@(posedge clock_i) disable iff (reset_i)
		(!reg_dout_en_i && !sel_eff) |=> (dout_o == 8'h00);
	endproperty
	a_unselected_zero: assert property (p_unselected_zero) else $error("unselected block drives data"); // [RQ8]

	property p_addr_drop;
		@(posedge clock_i) disable iff (reset_i)
		(org_i == csrb_pkg::ORG_256X8) && $stable(org_i) && $stable(addr_eff[7:0]) |-> $stable(base_eff);
	endproperty
	a_addr_drop: assert property (p_addr_drop) else $error("upper address bits used"); // [RQ10]

	property p_addr_reg_hold;
		@(posedge clock_i) disable iff (reset_i)
		(reg_addr_en_i && !in_tick) ##1 reg_addr_en_i |-> $stable(addr_eff);
	endproperty
	a_addr_reg_hold: assert property (p_addr_reg_hold) else $error("registered address moved"); // [RQ5]

	c_write: cover property (@(posedge clock_i) disable iff (reset_i) wr_strobe_o);
	c_lookup: cover property (@(posedge clock_i) disable iff (reset_i) rom_mode_i && dout_o != 8'h00);
	c_reg_out: cover property (@(posedge clock_i) disable iff (reset_i) reg_dout_en_i && out_tick);
	c_bit_wide: cover property (@(posedge clock_i) disable iff (reset_i)
		wr_pulse && org_i == csrb_pkg::ORG_2048X1);
endmodule

/* File: tb/csrb_user_model.sv */
// user logic model: raises one side clock candidate for one cycle on request
// assumes go_i and sel_i change just after clock_i rising edges
`timescale 1ns/1ps
module csrb_user_model
(
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic go_i,
	input wire logic [1:0] sel_i,
	output logic [2:0] src_o
);
	logic [2:0] src_r;
	logic [2:0] src_nxt;
	// ========================================
	// side clock level, low between pulses
	always_comb
	begin
		src_nxt = go_i ? 3'h1 << sel_i : 3'h0;
	end
	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
			src_r <= 3'h0;
		else
			src_r <= src_nxt;
	end
	assign src_o = src_r;
endmodule

/* File: tb/tb.sv */
// self-checking bench for the ram block: ratios, strobe, select, lookup, output register
// assumes csrb_pkg, csrb_ram_block and csrb_user_model are compiled first
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] org, isel, osel, pi, po;
	logic rom, rdi, rdo, rad, wg, wl, ws, sel, cl, cb, gi, go;
	logic [10:0] a, ca;
	logic [7:0] d;
	logic [7:0] q;
	logic st;
	logic [2:0] isrc, osrc;
	int n_mismatch = 0;
	int tests_run = 0;
	always #25 clk = ~clk;
	csrb_user_model u_in (.clock_i(clk), .reset_i(rst), .go_i(gi), .sel_i(pi), .src_o(isrc));
	csrb_user_model u_out (.clock_i(clk), .reset_i(rst), .go_i(go), .sel_i(po), .src_o(osrc));
	csrb_ram_block dut (.clock_i(clk), .reset_i(rst), .org_i(org), .rom_mode_i(rom), .reg_din_en_i(rdi),
		.reg_dout_en_i(rdo), .reg_addr_en_i(rad), .in_clk_src_i(isrc), .in_clk_sel_i(isel),
		.out_clk_src_i(osrc), .out_clk_sel_i(osel), .wr_req_global_i(wg), .wr_req_local_i(wl),
		.wr_src_sel_i(ws), .addr_i(a), .blk_sel_i(sel), .din_i(d), .cfg_load_i(cl),
		.cfg_addr_i(ca), .cfg_bit_i(cb), .dout_o(q), .wr_strobe_o(st));
	// ========================================
	// shared tasks
	task chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("unexpected at %0t ns: got %h expected %h", $time, g, e);
		end
	endtask
	// one write on an input tick; es is the expected strobe
	task wr(input logic [10:0] ad, input logic [7:0] dt, input logic lc, input logic es);
		@(posedge clk);
		a <= ad;
		d <= dt;
		ws <= lc;
		wg <= ~lc;
		wl <= lc;
		gi <= 1'b1;
		@(posedge clk);
		gi <= 1'b0;
		@(posedge clk);
		wg <= 1'b0;
		wl <= 1'b0;
		#1 chk({7'h00, st}, {7'h00, es});
		@(posedge clk);
		#1 chk({7'h00, st}, 8'h00);
	endtask
	task rd(input logic [10:0] ad, input logic [7:0] e);
		@(posedge clk);
		a <= ad;
		repeat (2) @(posedge clk);
		#1 chk(q, e);
	endtask
	task stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ========================================
	// scenarios
	task t_org();
		logic [7:0] m;
		for (int o = 0; o < 4; o++)
		begin
			@(posedge clk);
			org <= o[1:0];
			m = (8'h01 << (8 >> o)) - 8'h01;
			wr(11'h003, 8'hb7, o[0], 1'b1);
			rd(11'h003, 8'hb7 & m);
			rd(11'h003 | (11'h100 << o), 8'hb7 & m);
		end
		$display("test organisations done");
	endtask
	task t_sel();
		@(posedge clk);
		org <= 2'h0;
		sel <= 1'b0;
		wr(11'h005, 8'h5a, 1'b0, 1'b0);
		rd(11'h003, 8'h00);
		@(posedge clk);
		sel <= 1'b1;
		rd(11'h005, 8'h00);
		rd(11'h003, 8'hb7);
		$display("test block select done");
	endtask
	task t_rom();
		@(posedge clk);
		rom <= 1'b1;
		for (int k = 0; k < 8; k++)
		begin
			@(posedge clk);
			cl <= 1'b1;
			ca <= 11'h030 + k[10:0];
			cb <= k[2] ^ k[1];
		end
		@(posedge clk);
		cl <= 1'b0;
		wr(11'h006, 8'hff, 1'b0, 1'b0);
		rd(11'h006, 8'h3c);
		@(posedge clk);
		rom <= 1'b0;
		$display("test lookup done");
	endtask
	task t_ireg();
		@(posedge clk);
		rad <= 1'b1;
		rdi <= 1'b1;
		// first tick replays the request still held in the input registers
		wr(11'h009, 8'hc3, 1'b0, 1'b1);
		wr(11'h00a, 8'h3c, 1'b0, 1'b1);
		@(posedge clk);
		rad <= 1'b0;
		rdi <= 1'b0;
		rd(11'h009, 8'hc3);
		rd(11'h00a, 8'h00);
		$display("test input registers done");
	endtask
	task t_oreg();
		@(posedge clk);
		isel <= 2'h1;
		pi <= 2'h1;
		wr(11'h007, 8'h81, 1'b1, 1'b1);
		@(posedge clk);
		rdo <= 1'b1;
		osel <= 2'h2;
		po <= 2'h0;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		rd(11'h007, 8'h00);
		@(posedge clk);
		po <= 2'h2;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk(q, 8'h81);
		$display("test output register done");
	endtask
	// ========================================
	// main sequence
	initial
	begin
		{org, isel, osel, pi, po} = '0;
		{rom, rdi, rdo, rad, wg, wl, ws, cl, cb, gi, go} = '0;
		{a, ca, d} = '0;
		sel = 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		#1 chk(q, 8'h00);
		chk({7'h00, st}, 8'h00);
		$display("test reset done");
		t_org();
		t_sel();
		t_rom();
		t_ireg();
		t_oreg();
		stop_test();
	end
endmodule
